// [logic/sis_pkg.sv]
// Package for the slot interrupt status block: offsets, field layouts, reset values, carriers.
package sis_pkg;
	localparam int unsigned SIS_SLOTS        = 12;
	localparam int unsigned SIS_ADDR_W       = 8;
	localparam int unsigned SIS_DATA_W       = 16;
	localparam int unsigned SIS_FIFO_CNT_W   = 11;

	localparam logic [7:0] SIS_OFS_DATA_STATUS = 8'h01;
	localparam logic [7:0] SIS_OFS_LEV0_STATUS = 8'h02;
	localparam logic [7:0] SIS_OFS_LEV1_STATUS = 8'h03;
	localparam logic [7:0] SIS_OFS_AUTOCLEAR   = 8'h07;
	localparam logic [7:0] SIS_OFS_EN_X_DATA   = 8'h14;
	localparam logic [7:0] SIS_OFS_EN_Y_DATA   = 8'h15;
	localparam logic [7:0] SIS_OFS_EN_X_LEV0   = 8'h16;
	localparam logic [7:0] SIS_OFS_EN_X_LEV1   = 8'h17;
	localparam logic [7:0] SIS_OFS_EN_Y_LEV0   = 8'h1A;
	localparam logic [7:0] SIS_OFS_EN_Y_LEV1   = 8'h1B;

	localparam int unsigned SIS_FIFO_BIT = 15;

	localparam logic [11:0] SIS_SLOT_FLAGS_RST = 12'h000;
	localparam logic        SIS_FIFO_FLAG_RST  = 1'h0;
	localparam logic [11:0] SIS_SLOT_ACLR_RST  = 12'hFFF;
	localparam logic        SIS_FIFO_ACLR_RST  = 1'h1;
	localparam logic [12:0] SIS_ENABLE_RST     = 13'h0000;

	// Register access request from the serial register port.
	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} sis_reg_req_s;

	// Per-slot events from the data path, one-cycle pulses.
	typedef struct packed {
		logic [11:0] update;
		logic [11:0] lev0_met;
		logic [11:0] lev1_met;
		logic [11:0] data_read;
	} sis_slot_evt_s;

	// FIFO events and levels from the FIFO logic.
	typedef struct packed {
		logic        write;
		logic        read;
		logic [10:0] byte_count;
		logic [10:0] thresh_level;
	} sis_fifo_evt_s;
endpackage : sis_pkg

// [logic/sis_top.sv]
// Interrupt status flags, autoclear enables and X/Y routing for twelve time slots.
`timescale 1ns/1ps
`default_nettype none
module sis_top
	import sis_pkg::*;
(
	// Clock and reset
	input  wire logic          mclk_in,
	input  wire logic          rst_in,
	// Register access
	input  wire sis_reg_req_s  reg_req_in,
	output logic [15:0]        rd_data_out,
	output logic               rd_valid_out,
	// Event sources
	input  wire sis_slot_evt_s slot_evt_in,
	input  wire sis_fifo_evt_s fifo_evt_in,
	// Interrupt outputs
	output logic               int_x_out,
	output logic               int_y_out
);
	// Set wins over clear so an event in the clearing cycle is never lost.
	function automatic logic [11:0] w1c_next(input logic [11:0] cur, input logic [11:0] set,
		input logic [11:0] clr);
		w1c_next = set | (cur & ~clr);
	endfunction : w1c_next

	// A register is hit when a write strobe carries its offset.
	function automatic logic reg_hit(input sis_reg_req_s req, input logic [7:0] ofs);
		reg_hit = req.wr && (req.addr == ofs);
	endfunction : reg_hit

	// Shared read layout: bit 15 on top, slots in bits 11:0, reserved bits read zero.
	function automatic logic [15:0] word_of(input logic top, input logic [11:0] slots);
		word_of = {top, 3'h0, slots};
	endfunction : word_of

	logic [11:0] data_flags;
	logic [11:0] lev0_flags;
	logic [11:0] lev1_flags;
	logic        fifo_thresh_flag;
	logic [11:0] slot_aclr_en;
	logic        fifo_thresh_autoclear_en;
	logic [12:0] en_x_data;
	logic [12:0] en_y_data;
	logic [11:0] en_x_lev0;
	logic [11:0] en_x_lev1;
	logic [11:0] en_y_lev0;
	logic [11:0] en_y_lev1;

	wire [15:0] wd          = reg_req_in.wdata;
	wire        wr_data     = reg_hit(reg_req_in, SIS_OFS_DATA_STATUS);
	wire        wr_lev0     = reg_hit(reg_req_in, SIS_OFS_LEV0_STATUS);
	wire        wr_lev1     = reg_hit(reg_req_in, SIS_OFS_LEV1_STATUS);
	wire        wr_aclr     = reg_hit(reg_req_in, SIS_OFS_AUTOCLEAR);
	wire        wr_en_xd    = reg_hit(reg_req_in, SIS_OFS_EN_X_DATA);
	wire        wr_en_yd    = reg_hit(reg_req_in, SIS_OFS_EN_Y_DATA);
	wire        wr_en_x0    = reg_hit(reg_req_in, SIS_OFS_EN_X_LEV0);
	wire        wr_en_x1    = reg_hit(reg_req_in, SIS_OFS_EN_X_LEV1);
	wire        wr_en_y0    = reg_hit(reg_req_in, SIS_OFS_EN_Y_LEV0);
	wire        wr_en_y1    = reg_hit(reg_req_in, SIS_OFS_EN_Y_LEV1);

	wire [11:0] upd         = slot_evt_in.update;
	wire [11:0] data_set    = upd;
	wire [11:0] data_clr    = (wr_data ? wd[11:0] : 12'h000)
		| (slot_evt_in.data_read & slot_aclr_en);
	wire [11:0] lev0_set    = upd & slot_evt_in.lev0_met;
	wire [11:0] lev1_set    = upd & slot_evt_in.lev1_met;
	wire [11:0] lev0_clr    = wr_lev0 ? wd[11:0] : 12'h000;
	wire [11:0] lev1_clr    = wr_lev1 ? wd[11:0] : 12'h000;
	// A write that lands exactly at the threshold does not count; the count must exceed it.
	wire        fifo_set    = fifo_evt_in.write
		&& (fifo_evt_in.byte_count > fifo_evt_in.thresh_level);
	wire        fifo_clr    = (wr_data && wd[SIS_FIFO_BIT])
		|| (fifo_evt_in.read && fifo_thresh_autoclear_en);

	wire [11:0] next_data   = w1c_next(data_flags, data_set, data_clr);
	wire [11:0] next_lev0   = w1c_next(lev0_flags, lev0_set, lev0_clr);
	wire [11:0] next_lev1   = w1c_next(lev1_flags, lev1_set, lev1_clr);
	wire        next_fifo   = fifo_set || (fifo_thresh_flag && !fifo_clr);

	wire [12:0] data_vec    = {fifo_thresh_flag, data_flags};
	wire        x_data_hit  = |(data_vec & en_x_data);
	wire        x_lev0_hit  = |(lev0_flags & en_x_lev0);
	wire        x_lev1_hit  = |(lev1_flags & en_x_lev1);
	wire        y_data_hit  = |(data_vec & en_y_data);
	wire        y_lev0_hit  = |(lev0_flags & en_y_lev0);
	wire        y_lev1_hit  = |(lev1_flags & en_y_lev1);
	wire        next_int_x  = x_data_hit || x_lev0_hit || x_lev1_hit;
	wire        next_int_y  = y_data_hit || y_lev0_hit || y_lev1_hit;

	logic [15:0] next_rd_data;
	always_comb begin
		unique case (reg_req_in.addr)
			SIS_OFS_DATA_STATUS: next_rd_data = word_of(fifo_thresh_flag, data_flags);
			SIS_OFS_LEV0_STATUS: next_rd_data = word_of(1'h0, lev0_flags);
			SIS_OFS_LEV1_STATUS: next_rd_data = word_of(1'h0, lev1_flags);
			SIS_OFS_AUTOCLEAR:   next_rd_data = word_of(fifo_thresh_autoclear_en, slot_aclr_en);
			SIS_OFS_EN_X_DATA:   next_rd_data = word_of(en_x_data[12], en_x_data[11:0]);
			SIS_OFS_EN_Y_DATA:   next_rd_data = word_of(en_y_data[12], en_y_data[11:0]);
			SIS_OFS_EN_X_LEV0:   next_rd_data = word_of(1'h0, en_x_lev0);
			SIS_OFS_EN_X_LEV1:   next_rd_data = word_of(1'h0, en_x_lev1);
			SIS_OFS_EN_Y_LEV0:   next_rd_data = word_of(1'h0, en_y_lev0);
			SIS_OFS_EN_Y_LEV1:   next_rd_data = word_of(1'h0, en_y_lev1);
			default:             next_rd_data = 16'h0000;
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			data_flags <= SIS_SLOT_FLAGS_RST;
		end else begin
			data_flags <= next_data;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			lev0_flags <= SIS_SLOT_FLAGS_RST;
		end else begin
			lev0_flags <= next_lev0;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			lev1_flags <= SIS_SLOT_FLAGS_RST;
		end else begin
			lev1_flags <= next_lev1;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			fifo_thresh_flag <= SIS_FIFO_FLAG_RST;
		end else begin
			fifo_thresh_flag <= next_fifo;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			slot_aclr_en <= SIS_SLOT_ACLR_RST;
		end else if (wr_aclr) begin
			slot_aclr_en <= wd[11:0];
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			fifo_thresh_autoclear_en <= SIS_FIFO_ACLR_RST;
		end else if (wr_aclr) begin
			fifo_thresh_autoclear_en <= wd[SIS_FIFO_BIT];
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			en_x_data <= SIS_ENABLE_RST;
		end else if (wr_en_xd) begin
			en_x_data <= {wd[SIS_FIFO_BIT], wd[11:0]};
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			en_y_data <= SIS_ENABLE_RST;
		end else if (wr_en_yd) begin
			en_y_data <= {wd[SIS_FIFO_BIT], wd[11:0]};
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			en_x_lev0 <= SIS_ENABLE_RST[11:0];
		end else if (wr_en_x0) begin
			en_x_lev0 <= wd[11:0];
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			en_x_lev1 <= SIS_ENABLE_RST[11:0];
		end else if (wr_en_x1) begin
			en_x_lev1 <= wd[11:0];
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			en_y_lev0 <= SIS_ENABLE_RST[11:0];
		end else if (wr_en_y0) begin
			en_y_lev0 <= wd[11:0];
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			en_y_lev1 <= SIS_ENABLE_RST[11:0];
		end else if (wr_en_y1) begin
			en_y_lev1 <= wd[11:0];
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			rd_data_out  <= 16'h0000;
			rd_valid_out <= 1'h0;
		end else begin
			rd_data_out  <= reg_req_in.rd ? next_rd_data : 16'h0000;
			rd_valid_out <= reg_req_in.rd;
		end
	end

	// Interrupts lag their flags by one cycle so that both outputs come straight from flops.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			int_x_out <= 1'h0;
			int_y_out <= 1'h0;
		end else begin
			int_x_out <= next_int_x;
			int_y_out <= next_int_y;
		end
	end
endmodule : sis_top
`default_nettype wire

// [tb/sis_chk.sv]
// Checker for the slot interrupt status block, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module sis_chk
	import sis_pkg::*;
(
	// Clock and reset
	input wire logic          mclk_in,
	input wire logic          rst_in,
	// Register port
	input wire sis_reg_req_s  reg_req_in,
	input wire logic [15:0]   rd_data_out,
	input wire logic          rd_valid_out,
	// Event sources
	input wire sis_slot_evt_s slot_evt_in,
	input wire sis_fifo_evt_s fifo_evt_in,
	// Interrupt outputs
	input wire logic          int_x_out,
	input wire logic          int_y_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	wire rd1 = reg_req_in.rd && reg_req_in.addr == SIS_OFS_DATA_STATUS;
	wire rd2 = reg_req_in.rd && reg_req_in.addr == SIS_OFS_LEV0_STATUS;
	wire rd3 = reg_req_in.rd && reg_req_in.addr == SIS_OFS_LEV1_STATUS;
	wire rd7 = reg_req_in.rd && reg_req_in.addr == SIS_OFS_AUTOCLEAR;
	AST_RDV: assert property (reg_req_in.rd |=> rd_valid_out) else $error("no answer");
	AST_IDLE: assert property (
		!reg_req_in.rd |=> !rd_valid_out && rd_data_out == 16'h0000) else $error("stray read data");
	AST_RST: assert property (disable iff (1'h0)
		rst_in |=> !int_x_out && !int_y_out) else $error("interrupt in reset");
	AST_ACLR: assert property (disable iff (1'h0)
		$fell(rst_in) && rd7 |=> rd_data_out == 16'h8FFF) else $error("autoclear reset value");
	AST_SETD: assert property (
		slot_evt_in.update[0] ##1 rd1 |=> rd_data_out[0]) else $error("update flag not set");
	AST_SETL: assert property (
		slot_evt_in.update[11] && slot_evt_in.lev0_met[11] ##1 rd2 |=> rd_data_out[11])
		else $error("lev0");
	AST_FIFO: assert property (
		fifo_evt_in.write && fifo_evt_in.byte_count > fifo_evt_in.thresh_level ##1 rd1
		|=> rd_data_out[15]) else $error("fifo flag");
	AST_RSV7: assert property (rd7 |=> rd_data_out[14:12] == 3'h0)
		else $error("reserved");
	AST_RSV3: assert property (rd3 |=> rd_data_out[15:12] == 4'h0)
		else $error("lev1 reserved");
	cover property (int_x_out);
	cover property (int_y_out);
	cover property (rd_valid_out && rd_data_out != 16'h0000);
endmodule : sis_chk
bind sis_top sis_chk u_chk (.mclk_in, .rst_in, .reg_req_in, .rd_data_out, .rd_valid_out,
	.slot_evt_in, .fifo_evt_in, .int_x_out, .int_y_out);
`default_nettype wire

// [tb/sis_host.sv]
// Host model that presents one register request per call on the register port.
`timescale 1ns/1ps
`default_nettype none
module sis_host import sis_pkg::*; (output var sis_reg_req_s req_out);
	initial req_out = '0;
	// An idle port shows inverted address and data so a stale request can never look valid.
	task automatic put(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
		req_out = (w || r) ? '{addr: a, wdata: d, wr: w, rd: r}
			: '{addr: ~req_out.addr, wdata: ~req_out.wdata, wr: 1'h0, rd: 1'h0};
	endtask : put
endmodule : sis_host
`default_nettype wire

// [tb/tb_top.sv]
// Testbench: random events and register traffic checked against a behavioural model.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import sis_pkg::*;
	logic mclk_in = 1'h0, rst_in = 1'h1, rd_valid_out, int_x_out, int_y_out;
	logic ix = 1'h0, iy = 1'h0, erv = 1'h0;
	sis_reg_req_s req;
	sis_slot_evt_s sev = '0;
	sis_fifo_evt_s fev = '0;
	logic [15:0] rd_data_out, erd = 16'h0000, clr;
	logic [7:0] a;
	logic [15:0] m [0:31] = '{7: 16'h8FFF, default: 16'h0000};
	logic [15:0] mk [0:31] = '{1: 16'h8FFF, 7: 16'h8FFF, 20: 16'h8FFF, 21: 16'h8FFF,
		2: 16'h0FFF, 3: 16'h0FFF, 22: 16'h0FFF, 23: 16'h0FFF, 26: 16'h0FFF, 27: 16'h0FFF,
		default: 16'h0000};
	int bad_count = 0, cmp_count = 0, seed = 20982, r;
	always #2.5 mclk_in = ~mclk_in;
	sis_host host (.req_out(req));
	sis_top dut (.mclk_in, .rst_in, .reg_req_in(req), .rd_data_out, .rd_valid_out,
		.slot_evt_in(sev), .fifo_evt_in(fev), .int_x_out, .int_y_out);
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		cmp_count++;
		bad_count += int'(s !== e);
		if (s !== e)
			$display("ERROR %s expected %h seen %h", n, e, s);
	endtask : chk
	task automatic complete_run;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run
	initial begin
		repeat (3) @(posedge mclk_in);
		#1 rst_in = 1'h0;
		for (int k = 0; k < 4000; k++) begin
			chk("rd_data", erd, rd_data_out);
			chk("rd_valid", 16'(erv), 16'(rd_valid_out));
			chk("int_xy", 16'({ix, iy}), 16'({int_x_out, int_y_out}));
			ix = |(m[1] & m[20] | m[2] & m[22] | m[3] & m[23]);
			iy = |(m[1] & m[21] | m[2] & m[26] | m[3] & m[27]);
			r = $random(seed);
			a = (k == 0) ? 8'h07 : (r[7:5] == 3'h0) ? 8'hC3 : {3'h0, r[12:8]};
			erv = r[1] | (k == 0);
			sev = sis_slot_evt_s'(48'({$random(seed), $random(seed)}));
			fev = sis_fifo_evt_s'(24'($random(seed)));
			host.put(r[0], erv, a, r[31:16]);
			erd = (erv && a < 8'h20) ? m[a[4:0]] : 16'h0000;
			clr = {fev.read & m[7][15], 3'h0, sev.data_read & m[7][11:0]};
			if (r[0] && a < 8'h20) m[a[4:0]] = (a < 8'h04) ? m[a[4:0]] & ~(r[31:16] & mk[a[4:0]])
				: r[31:16] & mk[a[4:0]];
			m[1] = m[1] & ~clr | {fev.write && fev.byte_count > fev.thresh_level, 3'h0, sev.update};
			m[2] = m[2] | {4'h0, sev.update & sev.lev0_met};
			m[3] = m[3] | {4'h0, sev.update & sev.lev1_met};
			@(posedge mclk_in);
			#1;
		end
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
